// [rtl/osc_select_control.sv]
// Function
// - peripheral 4, byte access, offsets 0 1 2
// - source select bit, reset from pin
// - select change resets tile when enabled
// - internal oscillator fast or slow speed
// - internal oscillator enable, resets to one
// - crystal bias enable, resets to one
// - crystal oscillator enable, resets to one
module osc_select_control (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RESET,
	// configuration pin
	input  wire logic       SELECT_PIN,
	// peripheral access
	input  wire logic [7:0] PERIPH_NUM,
	input  wire logic [7:0] ADDR,
	input  wire logic       WR_EN,
	input  wire logic       RD_EN,
	input  wire logic [7:0] WDATA,
	output logic      [7:0] RDATA,
	output logic            RVALID,
	// oscillator controls
	output logic            USE_INTERNAL,
	output logic            INT_OSC_SLOW,
	output logic            INT_OSC_EN,
	output logic            XTAL_BIAS_EN,
	output logic            XTAL_OSC_EN,
	output logic            TILE_RESET
);
	osc_pkg::osc_state_t state_reg;
	logic                select_reg;
	logic                reset_en_reg;
	logic                int_slow_reg;
	logic                int_en_reg;
	logic                bias_en_reg;
	logic                xtal_en_reg;
	logic                hit;
	logic                wr_src;
	logic                wr_int;
	logic                wr_xtal;
	logic                trigger;
	logic [7:0]          rd_next;

	function automatic logic decode(input logic [7:0] num, input logic [7:0] a, input logic [7:0] ofs);
		decode = (num == osc_pkg::OSC_PERIPH_NUM) && (a == ofs);
	endfunction

	assign hit     = PERIPH_NUM == osc_pkg::OSC_PERIPH_NUM;
	assign wr_src  = WR_EN && decode(PERIPH_NUM, ADDR, osc_pkg::OSC_OFS_SOURCE);
	assign wr_int  = WR_EN && decode(PERIPH_NUM, ADDR, osc_pkg::OSC_OFS_INTERNAL);
	assign wr_xtal = WR_EN && decode(PERIPH_NUM, ADDR, osc_pkg::OSC_OFS_CRYSTAL);
	assign trigger = (state_reg == osc_pkg::OSC_ST_RUN) && wr_src && reset_en_reg
		&& (WDATA[osc_pkg::OSC_BIT_SELECT] != select_reg);

	// strap capture after reset release
	always_ff @(posedge CLK)
	begin
		if (RESET)
			state_reg <= osc_pkg::OSC_ST_BOOT;
		else
			state_reg <= osc_pkg::OSC_ST_RUN;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			select_reg <= 1'b0;
		else
			unique case (state_reg)
				osc_pkg::OSC_ST_BOOT: select_reg <= SELECT_PIN;
				osc_pkg::OSC_ST_RUN:
				begin
					if (wr_src)
						select_reg <= WDATA[osc_pkg::OSC_BIT_SELECT];
				end
				default: select_reg <= select_reg;
			endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			reset_en_reg <= osc_pkg::OSC_RST_RESET_EN;
		else if (wr_src)
			reset_en_reg <= WDATA[osc_pkg::OSC_BIT_RESET_EN];
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			int_slow_reg <= osc_pkg::OSC_RST_INT_SLOW;
			int_en_reg   <= osc_pkg::OSC_RST_INT_ENABLE;
		end
		else if (wr_int)
		begin
			int_slow_reg <= WDATA[osc_pkg::OSC_BIT_INT_SLOW];
			int_en_reg   <= WDATA[osc_pkg::OSC_BIT_INT_ENABLE];
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			bias_en_reg <= osc_pkg::OSC_RST_BIAS_EN;
			xtal_en_reg <= osc_pkg::OSC_RST_XTAL_EN;
		end
		else if (wr_xtal)
		begin
			bias_en_reg <= WDATA[osc_pkg::OSC_BIT_BIAS_EN];
			xtal_en_reg <= WDATA[osc_pkg::OSC_BIT_XTAL_EN];
		end
	end

	// read mux, upper bits zero
	always_comb
	begin
		rd_next = 8'h00;
		if (hit)
			unique case (ADDR)
				osc_pkg::OSC_OFS_SOURCE:   rd_next = {6'h00, reset_en_reg, select_reg};
				osc_pkg::OSC_OFS_INTERNAL: rd_next = {6'h00, int_slow_reg, int_en_reg};
				osc_pkg::OSC_OFS_CRYSTAL:  rd_next = {6'h00, bias_en_reg, xtal_en_reg};
				default:                   rd_next = 8'h00;
			endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			RDATA  <= 8'h00;
			RVALID <= 1'b0;
		end
		else
		begin
			RDATA  <= RD_EN ? rd_next : 8'h00;
			RVALID <= RD_EN && hit;
		end
	end

	// outputs registered
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			USE_INTERNAL <= 1'b0;
			INT_OSC_SLOW <= osc_pkg::OSC_RST_INT_SLOW;
			INT_OSC_EN   <= osc_pkg::OSC_RST_INT_ENABLE;
			XTAL_BIAS_EN <= osc_pkg::OSC_RST_BIAS_EN;
			XTAL_OSC_EN  <= osc_pkg::OSC_RST_XTAL_EN;
		end
		else
		begin
			USE_INTERNAL <= select_reg;
			INT_OSC_SLOW <= int_slow_reg;
			INT_OSC_EN   <= int_en_reg;
			XTAL_BIAS_EN <= bias_en_reg;
			XTAL_OSC_EN  <= xtal_en_reg;
		end
	end

	osc_tile_reset u_tile_reset (
		.clk        (CLK),
		.reset      (RESET),
		.trigger    (trigger),
		.tile_reset (TILE_RESET)
	);

	// checks
	sequence s_sel_change;
		wr_src && reset_en_reg && (state_reg == osc_pkg::OSC_ST_RUN)
			&& (WDATA[osc_pkg::OSC_BIT_SELECT] != select_reg);
	endsequence

	sequence s_tile_pulse;
		TILE_RESET [*4];
	endsequence

	property p_tile_reset_on_change;
		@(posedge CLK) disable iff (RESET) s_sel_change |=> s_tile_pulse;
	endproperty
	a_tile_reset_on_change: assert property (p_tile_reset_on_change) else $error("tile reset missing");

	property p_no_reset_when_off;
		@(posedge CLK) disable iff (RESET) (!reset_en_reg && !TILE_RESET) |=> !TILE_RESET || $past(trigger);
	endproperty
	a_no_reset_when_off: assert property (p_no_reset_when_off) else $error("spurious tile reset");

	property p_strap;
		@(posedge CLK) (state_reg == osc_pkg::OSC_ST_BOOT) && !RESET |=> select_reg == $past(SELECT_PIN);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not captured");

	property p_sel_out;
		@(posedge CLK) disable iff (RESET) wr_src && (state_reg == osc_pkg::OSC_ST_RUN)
			|=> ##1 USE_INTERNAL == $past(WDATA[osc_pkg::OSC_BIT_SELECT], 2);
	endproperty
	a_sel_out: assert property (p_sel_out) else $error("select not applied");

	property p_int_write;
		@(posedge CLK) disable iff (RESET) wr_int |=> ##1 (INT_OSC_EN == $past(WDATA[0], 2))
			&& (INT_OSC_SLOW == $past(WDATA[1], 2));
	endproperty
	a_int_write: assert property (p_int_write) else $error("internal control wrong");

	property p_xtal_write;
		@(posedge CLK) disable iff (RESET) wr_xtal |=> ##1 (XTAL_OSC_EN == $past(WDATA[0], 2))
			&& (XTAL_BIAS_EN == $past(WDATA[1], 2));
	endproperty
	a_xtal_write: assert property (p_xtal_write) else $error("crystal control wrong");

	property p_reserved_zero;
		@(posedge CLK) disable iff (RESET) RDATA[7:2] == 6'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

	property p_read_back;
		@(posedge CLK) disable iff (RESET) RD_EN && decode(PERIPH_NUM, ADDR, osc_pkg::OSC_OFS_CRYSTAL) && !WR_EN
			|=> RVALID && (RDATA[1:0] == {bias_en_reg, xtal_en_reg});
	endproperty
	a_read_back: assert property (p_read_back) else $error("crystal readback wrong");
endmodule

// [rtl/osc_pkg.sv]
package osc_pkg;
	localparam logic [7:0] OSC_PERIPH_NUM     = 8'h04;
	localparam logic [7:0] OSC_OFS_SOURCE     = 8'h00;
	localparam logic [7:0] OSC_OFS_INTERNAL   = 8'h01;
	localparam logic [7:0] OSC_OFS_CRYSTAL    = 8'h02;
	localparam int         OSC_BIT_SELECT     = 0;
	localparam int         OSC_BIT_RESET_EN   = 1;
	localparam int         OSC_BIT_INT_ENABLE = 0;
	localparam int         OSC_BIT_INT_SLOW   = 1;
	localparam int         OSC_BIT_XTAL_EN    = 0;
	localparam int         OSC_BIT_BIAS_EN    = 1;
	localparam logic       OSC_RST_RESET_EN   = 1'b0;
	localparam logic       OSC_RST_INT_SLOW   = 1'b0;
	localparam logic       OSC_RST_INT_ENABLE = 1'b1;
	localparam logic       OSC_RST_BIAS_EN    = 1'b1;
	localparam logic       OSC_RST_XTAL_EN    = 1'b1;
	localparam logic [3:0] OSC_TILE_RST_CYCLES = 4'h4;
	localparam logic [7:0] OSC_FAST_HZ_M      = 8'h14;
	localparam int         OSC_SLOW_HZ        = 31250;
	typedef enum logic [1:0] {
		OSC_ST_BOOT = 2'b00,
		OSC_ST_RUN  = 2'b01
	} osc_state_t;
endpackage

// [rtl/osc_tile_reset.sv]
module osc_tile_reset (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// trigger
	input  wire logic trigger,
	// output
	output logic      tile_reset
);
	logic [3:0] count_reg;

	always_ff @(posedge clk)
	begin
		if (reset)
			count_reg <= 4'h0;
		else if (trigger)
			count_reg <= osc_pkg::OSC_TILE_RST_CYCLES;
		else if (count_reg != 4'h0)
			count_reg <= count_reg - 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			tile_reset <= 1'b0;
		else
			tile_reset <= trigger || (count_reg > 4'h1);
	end
endmodule

// [sim/osc_select_control_bench.sv]
module osc_select_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       CLK = 1'b0;
	logic       RESET = 1'b1;
	logic       SELECT_PIN = 1'b1;
	logic [7:0] PERIPH_NUM = 8'h00;
	logic [7:0] ADDR = 8'h00;
	logic       WR_EN = 1'b0;
	logic       RD_EN = 1'b0;
	logic [7:0] WDATA = 8'h00;
	logic [7:0] RDATA;
	logic       RVALID;
	logic       USE_INTERNAL;
	logic       INT_OSC_SLOW;
	logic       INT_OSC_EN;
	logic       XTAL_BIAS_EN;
	logic       XTAL_OSC_EN;
	logic       TILE_RESET;
	int         err_total = 0;
	int         compares = 0;
	logic [7:0] cnt;
	osc_select_control dut (
		.CLK          (CLK),
		.RESET        (RESET),
		.SELECT_PIN   (SELECT_PIN),
		.PERIPH_NUM   (PERIPH_NUM),
		.ADDR         (ADDR),
		.WR_EN        (WR_EN),
		.RD_EN        (RD_EN),
		.WDATA        (WDATA),
		.RDATA        (RDATA),
		.RVALID       (RVALID),
		.USE_INTERNAL (USE_INTERNAL),
		.INT_OSC_SLOW (INT_OSC_SLOW),
		.INT_OSC_EN   (INT_OSC_EN),
		.XTAL_BIAS_EN (XTAL_BIAS_EN),
		.XTAL_OSC_EN  (XTAL_OSC_EN),
		.TILE_RESET   (TILE_RESET)
	);
	always #10 CLK = ~CLK;
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// byte write, inputs change on falling edge
	task automatic wr(input logic [7:0] pn, input logic [7:0] ofs, input logic [7:0] d);
		// idle cycle first, so a strobe never rises where it just fell
		@(negedge CLK);
		PERIPH_NUM = pn;
		ADDR = ofs;
		WDATA = d;
		WR_EN = 1'b1;
		@(negedge CLK);
		WR_EN = 1'b0;
	endtask
	// byte read, answer checked one cycle later
	task automatic rd(input logic [7:0] pn, input logic [7:0] ofs, input logic [7:0] exp, input logic v);
		// idle cycle first, so a strobe never rises where it just fell
		@(negedge CLK);
		PERIPH_NUM = pn;
		ADDR = ofs;
		RD_EN = 1'b1;
		@(negedge CLK);
		RD_EN = 1'b0;
		chk("rvalid", {7'h00, v}, {7'h00, RVALID});
		chk("rdata", exp, RDATA);
	endtask
	// control outputs, sampled once settled
	task automatic outs(input logic [7:0] exp);
		@(negedge CLK);
		chk("controls", exp, {3'h0, USE_INTERNAL, INT_OSC_SLOW, INT_OSC_EN, XTAL_BIAS_EN, XTAL_OSC_EN});
	endtask
	// tile reset length over eight cycles
	task automatic tile(input logic [7:0] exp);
		cnt = 8'h00;
		repeat (8)
		begin
			cnt = cnt + {7'h00, TILE_RESET};
			@(negedge CLK);
		end
		chk("tile_reset_len", exp, cnt);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (2000) @(posedge CLK);
		err_total++;
		conclude();
	end
	initial
	begin
		repeat (12) @(negedge CLK);
		RESET = 1'b0;
		repeat (3) @(negedge CLK);
		outs(8'h17);
		rd(8'h04, 8'h00, 8'h01, 1'b1);
		rd(8'h04, 8'h01, 8'h01, 1'b1);
		rd(8'h04, 8'h02, 8'h03, 1'b1);
		wr(8'h04, 8'h01, 8'hFF);
		rd(8'h04, 8'h01, 8'h03, 1'b1);
		outs(8'h1F);
		// move to the crystal before stopping the internal oscillator
		wr(8'h04, 8'h00, 8'h00);
		tile(8'h00);
		rd(8'h04, 8'h00, 8'h00, 1'b1);
		wr(8'h04, 8'h01, 8'h00);
		outs(8'h03);
		// back to the internal oscillator before stopping the crystal
		wr(8'h04, 8'h01, 8'h01);
		wr(8'h04, 8'h00, 8'h01);
		tile(8'h00);
		// an external oscillator is assumed on the crystal input
		wr(8'h04, 8'h02, 8'hFC);
		rd(8'h04, 8'h02, 8'h00, 1'b1);
		outs(8'h14);
		wr(8'h04, 8'h02, 8'h02);
		outs(8'h16);
		rd(8'h04, 8'h03, 8'h00, 1'b1);
		rd(8'h05, 8'h01, 8'h00, 1'b0);
		wr(8'h05, 8'h01, 8'h03);
		rd(8'h04, 8'h01, 8'h01, 1'b1);
		wr(8'h04, 8'h02, 8'h03);
		wr(8'h04, 8'h00, 8'h02);
		tile(8'h00);
		rd(8'h04, 8'h00, 8'h02, 1'b1);
		wr(8'h04, 8'h00, 8'h03);
		tile({4'h0, osc_pkg::OSC_TILE_RST_CYCLES});
		rd(8'h04, 8'h00, 8'h03, 1'b1);
		outs(8'h17);
		wr(8'h04, 8'h00, 8'hFE);
		tile({4'h0, osc_pkg::OSC_TILE_RST_CYCLES});
		rd(8'h04, 8'h00, 8'h02, 1'b1);
		wr(8'h04, 8'h00, 8'h02);
		tile(8'h00);
		RESET = 1'b1;
		SELECT_PIN = 1'b0;
		repeat (12) @(negedge CLK);
		RESET = 1'b0;
		repeat (3) @(negedge CLK);
		rd(8'h04, 8'h00, 8'h00, 1'b1);
		outs(8'h07);
		conclude();
	end
endmodule
